// ==== rtl/sdm_regs.vh ====
// Register map, field positions, reset values and encodings of the dual-mode selector
// Functional notes
// - Codes 06, 07: pulse position with speed/torque
// - Codes 08, 09, 10: table/speed, table/torque, speed/torque
// - No zero-speed or zero-torque dual halves
// - Position source: table parameters or external pulses
// - Speed command: analog or three speed parameters
// - Speed half ON: speed selects, trigger ignored
// - Switch from speed to table position: hold stopped until trigger
// - Trigger edge selects table target, move now
// - Speed/position switch ON reverts to speed
// - Speed/torque ON: torque selects, speed ignored
// - Speed/torque OFF: speed mode, immediate return
// - Torque command: analog or three torque parameters
// - Torque/pulse position ON: count command pulses
// - Torque/position OFF: stop counting, follow torque
// - Torque/position ON reverts to position immediately
// - Torque dual position source: pulses or table
// - Torque selection applies only after servo on
// - Input OFF is open, ON is closed
// - Speed capped at maximum in all modes
// - Speed limit only in torque mode
// - Speed limit active only when enable is 1
// - Nonzero torque select uses internal parameter
`ifndef SDM_REGS_VH
`define SDM_REGS_VH
`define SDM_ADR_CTRL      8'h00
`define SDM_ADR_SPD1      8'h04
`define SDM_ADR_SPD2      8'h08
`define SDM_ADR_SPD3      8'h0C
`define SDM_ADR_TRQ1      8'h10
`define SDM_ADR_TRQ2      8'h14
`define SDM_ADR_TRQ3      8'h18
`define SDM_ADR_MAXSPD    8'h1C
`define SDM_ADR_STATUS    8'h20
`define SDM_ADR_PCOUNT    8'h24
`define SDM_ADR_POS_BASE  8'h40
`define SDM_CTRL_CODE_LSB 0
`define SDM_CTRL_CODE_MSB 3
`define SDM_CTRL_TANALOG  4
`define SDM_CTRL_LIMEN    5
`define SDM_CTRL_RST      32'h0000_0000
`define SDM_MAXSPD_RST    16'h7FFF
`define SDM_CODE_PT_S     4'h6
`define SDM_CODE_PT_T     4'h7
`define SDM_CODE_PR_S     4'h8
`define SDM_CODE_PR_T     4'h9
`define SDM_CODE_S_T      4'hA
`define SDM_MODE_IDLE     3'h0
`define SDM_MODE_PULSE    3'h1
`define SDM_MODE_TABLE    3'h2
`define SDM_MODE_SPEED    3'h3
`define SDM_MODE_TORQUE   3'h4
`endif

// ==== rtl/sdm_dual_mode_selector.v ====
// Dual control-mode selector with command multiplexing and speed capping
//
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "sdm_regs.vh"
module sdm_dual_mode_selector #(
   parameter CW = 16
) (
   input  wire          clk_i,
   input  wire          rst_i,
   input  wire          cyc_i,
   input  wire          stb_i,
   input  wire          we_i,
   input  wire [7:0]    adr_i,
   input  wire [3:0]    sel_i,
   input  wire [31:0]   dat_i,
   output reg  [31:0]   dat_o,
   output reg           ack_o,
   input  wire          mode_switch_i,
   input  wire [1:0]    speed_cmd_select_i,
   input  wire [1:0]    torque_cmd_select_i,
   input  wire [2:0]    position_cmd_select_i,
   input  wire          position_trigger_i,
   input  wire          servo_on_input_i,
   input  wire          pulse_i,
   input  wire          pulse_dir_i,
   input  wire [CW-1:0] analog_speed_i,
   input  wire [CW-1:0] analog_torque_i,
   output reg  [2:0]    active_mode_o,
   output reg  [CW-1:0] speed_cmd_o,
   output reg  [CW-1:0] torque_cmd_o,
   output reg  [CW-1:0] speed_limit_o,
   output reg           speed_limit_en_o,
   output reg  [31:0]   position_cmd_o,
   output reg           position_valid_o,
   output reg           motor_hold_o
);
   localparam NIN = 12;
   localparam [1:0] ST_SPEEDSIDE = 2'd0;
   localparam [1:0] ST_WAITTRIG  = 2'd1;
   localparam [1:0] ST_MOVING    = 2'd2;

   // Three-stage input synchroniser; a change counts when stages 2 and 3 agree
   reg  [NIN-1:0] s1_q;
   reg  [NIN-1:0] s2_q;
   reg  [NIN-1:0] s3_q;
   reg  [NIN-1:0] in_q;
   wire [NIN-1:0] raw_in;
   assign raw_in = {pulse_dir_i, pulse_i, servo_on_input_i, position_trigger_i,
                    position_cmd_select_i, torque_cmd_select_i, speed_cmd_select_i, mode_switch_i};

   // Accept a new level only once stages 2 and 3 agree
   wire [NIN-1:0] agree = ~(s2_q ^ s3_q);
   wire [NIN-1:0] in_d  = (agree & s3_q) | (~agree & in_q);
   always @(posedge clk_i) begin
      if (rst_i) begin
         s1_q <= {NIN{1'b0}};
         s2_q <= {NIN{1'b0}};
         s3_q <= {NIN{1'b0}};
         in_q <= {NIN{1'b0}};
      end else begin
         s1_q <= raw_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         in_q <= in_d;
      end
   end
   // Active high means the contact is closed (ON)
   wire       sw_on   = in_q[0];
   wire [1:0] spd_sel = in_q[2:1];
   wire [1:0] trq_sel = in_q[4:3];
   wire [2:0] pos_sel = in_q[7:5];
   wire       trig    = in_q[8];
   wire       servo_on_input     = in_q[9];
   wire       pulse   = in_q[10];
   wire       pdir    = in_q[11];
   reg        trig_prev_q;
   reg        pulse_prev_q;
   wire       trig_rise  = trig & ~trig_prev_q;
   wire       pulse_rise = pulse & ~pulse_prev_q;

   // Configuration and parameter store
   reg [31:0]   ctrl_q;
   reg [CW-1:0] spd_par_q [0:2];
   reg [CW-1:0] trq_par_q [0:2];
   reg [CW-1:0] maxspd_q;
   reg [31:0]   pos_tab_q [0:7];
   reg [31:0]   pcount_q;
   reg [1:0]    pst_q;
   reg [1:0]    trq_sel_q;

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  be;
      integer k;
      begin
         for (k = 0; k < 4; k = k + 1)
            merge[k*8 +: 8] = be[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
      end
   endfunction

   // Shared command source selection: 0 picks analog or zero, else a parameter
   function [CW-1:0] pick;
      input [1:0]    s;
      input [CW-1:0] ext;
      input [CW-1:0] p1;
      input [CW-1:0] p2;
      input [CW-1:0] p3;
      begin
         case (s)
            2'd1:    pick = p1;
            2'd2:    pick = p2;
            2'd3:    pick = p3;
            default: pick = ext;
         endcase
      end
   endfunction

   function [CW-1:0] cap;
      input [CW-1:0] v;
      input [CW-1:0] lim;
      begin
         if ($signed(v) > $signed(lim))
            cap = lim;
         else if ($signed(v) < -$signed(lim))
            cap = -lim;
         else
            cap = v;
      end
   endfunction

   // Position-side modes: pulse train or table target
   function is_pos_mode;
      input [2:0] m;
      begin
         is_pos_mode = (m == `SDM_MODE_TABLE) || (m == `SDM_MODE_PULSE);
      end
   endfunction

   // Zero-extend a command word to the bus width
   function [31:0] widen;
      input [CW-1:0] v;
      begin
         widen = {{(32-CW){1'b0}}, v};
      end
   endfunction

   // Mode decode; only codes 06..10 enable dual switching, no zero variants
   wire [3:0] code = ctrl_q[`SDM_CTRL_CODE_MSB:`SDM_CTRL_CODE_LSB];
   reg  [2:0] mode_d;
   reg        pos_is_table;
   reg        spd_pos_dual;
   always @* begin
      mode_d       = `SDM_MODE_IDLE;
      pos_is_table = 1'b0;
      spd_pos_dual = 1'b0;
      case (code)
         `SDM_CODE_PT_S: begin
            spd_pos_dual = 1'b1;
            mode_d       = sw_on ? `SDM_MODE_SPEED : `SDM_MODE_PULSE;
         end
         `SDM_CODE_PT_T: begin
            mode_d = sw_on ? `SDM_MODE_PULSE : `SDM_MODE_TORQUE;
         end
         `SDM_CODE_PR_S: begin
            spd_pos_dual = 1'b1;
            pos_is_table = 1'b1;
            mode_d       = sw_on ? `SDM_MODE_SPEED : `SDM_MODE_TABLE;
         end
         `SDM_CODE_PR_T: begin
            pos_is_table = 1'b1;
            mode_d       = sw_on ? `SDM_MODE_TABLE : `SDM_MODE_TORQUE;
         end
         `SDM_CODE_S_T: begin
            mode_d = sw_on ? `SDM_MODE_TORQUE : `SDM_MODE_SPEED;
         end
         default: mode_d = `SDM_MODE_IDLE;
      endcase
   end

   // Wishbone classic slave, one wait state, drops ack after one cycle
   wire req  = cyc_i & stb_i & ~ack_o;
   wire wr   = req & we_i;
   wire ptab = (adr_i[7:5] == 3'b010);

   // Read data selection, registered when a request is taken
   reg [31:0] rd_d;
   always @* begin
      rd_d = 32'h0000_0000;
      case (adr_i)
         `SDM_ADR_CTRL:   rd_d = ctrl_q;
         `SDM_ADR_SPD1:   rd_d = widen(spd_par_q[0]);
         `SDM_ADR_SPD2:   rd_d = widen(spd_par_q[1]);
         `SDM_ADR_SPD3:   rd_d = widen(spd_par_q[2]);
         `SDM_ADR_TRQ1:   rd_d = widen(trq_par_q[0]);
         `SDM_ADR_TRQ2:   rd_d = widen(trq_par_q[1]);
         `SDM_ADR_TRQ3:   rd_d = widen(trq_par_q[2]);
         `SDM_ADR_MAXSPD: rd_d = widen(maxspd_q);
         `SDM_ADR_STATUS: rd_d = {24'h00_0000, motor_hold_o, position_valid_o, pst_q, 1'b0, active_mode_o};
         `SDM_ADR_PCOUNT: rd_d = pcount_q;
         default: begin
            if (ptab)
               rd_d = pos_tab_q[adr_i[4:2]];
         end
      endcase
   end

   integer i;
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o    <= 1'b0;
         dat_o    <= 32'h0000_0000;
         ctrl_q   <= `SDM_CTRL_RST;
         maxspd_q <= `SDM_MAXSPD_RST;
         for (i = 0; i < 3; i = i + 1) begin
            spd_par_q[i] <= {CW{1'b0}};
            trq_par_q[i] <= {CW{1'b0}};
         end
         for (i = 0; i < 8; i = i + 1)
            pos_tab_q[i] <= 32'h0000_0000;
      end else begin
         ack_o <= req;
         if (wr) begin
            case (adr_i)
               `SDM_ADR_CTRL:   ctrl_q       <= merge(ctrl_q, dat_i, sel_i) & 32'h0000_003F;
               `SDM_ADR_SPD1:   spd_par_q[0] <= dat_i[CW-1:0];
               `SDM_ADR_SPD2:   spd_par_q[1] <= dat_i[CW-1:0];
               `SDM_ADR_SPD3:   spd_par_q[2] <= dat_i[CW-1:0];
               `SDM_ADR_TRQ1:   trq_par_q[0] <= dat_i[CW-1:0];
               `SDM_ADR_TRQ2:   trq_par_q[1] <= dat_i[CW-1:0];
               `SDM_ADR_TRQ3:   trq_par_q[2] <= dat_i[CW-1:0];
               `SDM_ADR_MAXSPD: maxspd_q     <= dat_i[CW-1:0];
               default: begin
                  if (ptab)
                     pos_tab_q[adr_i[4:2]] <= merge(pos_tab_q[adr_i[4:2]], dat_i, sel_i);
               end
            endcase
         end
         if (req)
            dat_o <= rd_d;
      end
   end

   // Position sequencing and pulse counting: next values
   reg [1:0]  pst_d;
   reg [31:0] pcount_d;
   reg [31:0] position_cmd_d;
   reg        position_valid_d;
   reg        motor_hold_d;
   reg [1:0]  trq_sel_d;

   always @* begin
      pst_d            = pst_q;
      pcount_d         = pcount_q;
      position_cmd_d   = position_cmd_o;
      position_valid_d = position_valid_o;
      motor_hold_d     = motor_hold_o;
      trq_sel_d        = trq_sel_q;
      if (servo_on_input)
         trq_sel_d = trq_sel;
      if (mode_d == `SDM_MODE_PULSE && pulse_rise) begin
         if (pdir)
            pcount_d = pcount_q - 32'h0000_0001;
         else
            pcount_d = pcount_q + 32'h0000_0001;
      end
      case (pst_q)
         ST_SPEEDSIDE: begin
            position_valid_d = 1'b0;
            motor_hold_d     = 1'b0;
            if (is_pos_mode(mode_d)) begin
               if (spd_pos_dual && pos_is_table) begin
                  pst_d        = ST_WAITTRIG;
                  motor_hold_d = 1'b1;
               end else begin
                  pst_d = ST_MOVING;
               end
            end
         end
         ST_WAITTRIG: begin
            // Target stays undetermined until a trigger edge
            if (mode_d != `SDM_MODE_TABLE) begin
               pst_d        = ST_SPEEDSIDE;
               motor_hold_d = 1'b0;
            end else if (trig_rise) begin
               position_cmd_d   = pos_tab_q[pos_sel];
               position_valid_d = 1'b1;
               motor_hold_d     = 1'b0;
               pst_d            = ST_MOVING;
            end
         end
         ST_MOVING: begin
            if (!is_pos_mode(mode_d)) begin
               pst_d            = ST_SPEEDSIDE;
               position_valid_d = 1'b0;
            end else begin
               position_valid_d = 1'b1;
               if (mode_d == `SDM_MODE_PULSE)
                  position_cmd_d = pcount_q;
               else if (!spd_pos_dual && trig_rise)
                  position_cmd_d = pos_tab_q[pos_sel];
            end
         end
         default: pst_d = ST_SPEEDSIDE;
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         trig_prev_q      <= 1'b0;
         pulse_prev_q     <= 1'b0;
         pst_q            <= ST_SPEEDSIDE;
         pcount_q         <= 32'h0000_0000;
         position_cmd_o   <= 32'h0000_0000;
         position_valid_o <= 1'b0;
         motor_hold_o     <= 1'b0;
         active_mode_o    <= `SDM_MODE_IDLE;
         trq_sel_q        <= 2'b00;
      end else begin
         trig_prev_q      <= trig;
         pulse_prev_q     <= pulse;
         pst_q            <= pst_d;
         pcount_q         <= pcount_d;
         position_cmd_o   <= position_cmd_d;
         position_valid_o <= position_valid_d;
         motor_hold_o     <= motor_hold_d;
         active_mode_o    <= mode_d;
         trq_sel_q        <= trq_sel_d;
      end
   end

   // Command outputs
   wire [CW-1:0] t1    = ctrl_q[`SDM_CTRL_TANALOG] ? analog_torque_i : {CW{1'b0}};
   wire [CW-1:0] spd_c = pick(spd_sel, analog_speed_i, spd_par_q[0], spd_par_q[1], spd_par_q[2]);
   wire [CW-1:0] trq_c = pick(trq_sel_q, t1, trq_par_q[0], trq_par_q[1], trq_par_q[2]);
   wire          lim_on = ctrl_q[`SDM_CTRL_LIMEN] & (mode_d == `SDM_MODE_TORQUE);

   reg  [CW-1:0] speed_cmd_d;
   reg  [CW-1:0] torque_cmd_d;
   reg  [CW-1:0] speed_limit_d;
   reg           speed_limit_en_d;

   always @* begin
      speed_cmd_d      = {CW{1'b0}};
      torque_cmd_d     = {CW{1'b0}};
      speed_limit_d    = maxspd_q;
      speed_limit_en_d = 1'b0;
      if (mode_d == `SDM_MODE_SPEED) begin
         speed_cmd_d = cap(spd_c, maxspd_q);
      end
      if (mode_d == `SDM_MODE_TORQUE && servo_on_input) begin
         torque_cmd_d = trq_c;
      end
      if (lim_on) begin
         speed_limit_d    = cap(spd_c, maxspd_q);
         speed_limit_en_d = 1'b1;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         speed_cmd_o      <= {CW{1'b0}};
         torque_cmd_o     <= {CW{1'b0}};
         speed_limit_o    <= {CW{1'b0}};
         speed_limit_en_o <= 1'b0;
      end else begin
         speed_cmd_o      <= speed_cmd_d;
         torque_cmd_o     <= torque_cmd_d;
         speed_limit_o    <= speed_limit_d;
         speed_limit_en_o <= speed_limit_en_d;
      end
   end
endmodule

// ==== tb/sdm_asserts.sv ====
// Port-level assertions for the dual-mode selector
`timescale 1ns/1ps
module sdm_asserts #(
   parameter CW = 16
) (
   input wire          clk_i,
   input wire          rst_i,
   input wire          cyc_i,
   input wire          stb_i,
   input wire          ack_o,
   input wire          servo_on_input_i,
   input wire          position_trigger_i,
   input wire [2:0]    active_mode_o,
   input wire [CW-1:0] speed_cmd_o,
   input wire [CW-1:0] torque_cmd_o,
   input wire          speed_limit_en_o,
   input wire          position_valid_o,
   input wire          motor_hold_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req; cyc_i && stb_i && !ack_o; endsequence
   sequence s_trig; $rose(position_trigger_i) && motor_hold_o; endsequence
   property p_ack_next; s_req |=> ack_o; endproperty
   property p_ack_once; ack_o |=> !ack_o; endproperty
   property p_ack_idle; !(cyc_i && stb_i) |=> !ack_o; endproperty
   property p_mode_legal; active_mode_o <= 3'h4; endproperty
   property p_torque_off; !servo_on_input_i [*8] |-> torque_cmd_o == 0; endproperty
   property p_speed_zero; (active_mode_o != 3'h3) [*3] |-> speed_cmd_o == 0; endproperty
   property p_limit_torque; (active_mode_o != 3'h4) [*3] |-> !speed_limit_en_o; endproperty
   property p_hold_valid; motor_hold_o |-> !position_valid_o; endproperty
   property p_trig_move; s_trig |-> ##[1:16] (position_valid_o && !motor_hold_o); endproperty
   a_ack_next: assert property (p_ack_next) else $error("request not acknowledged");
   a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
   a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
   a_mode_legal: assert property (p_mode_legal) else $error("illegal mode");
   a_torque_off: assert property (p_torque_off) else $error("torque without servo on");
   a_speed_zero: assert property (p_speed_zero) else $error("speed outside speed mode");
   a_limit_torque: assert property (p_limit_torque) else $error("limit outside torque");
   a_hold_valid: assert property (p_hold_valid) else $error("hold with valid target");
   a_trig_move: assert property (p_trig_move) else $error("trigger did not move");
endmodule
bind sdm_dual_mode_selector sdm_asserts #(.CW(CW)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
   .servo_on_input_i(servo_on_input_i), .position_trigger_i(position_trigger_i),
   .active_mode_o(active_mode_o), .speed_cmd_o(speed_cmd_o), .torque_cmd_o(torque_cmd_o),
   .speed_limit_en_o(speed_limit_en_o), .position_valid_o(position_valid_o),
   .motor_hold_o(motor_hold_o));

// ==== tb/sdm_ctrl_model.sv ====
// Behavioural motion controller driving the selector's digital inputs
`timescale 1ns/1ps
module sdm_ctrl_model (
   input  wire       clk_i,
   output reg        mode_switch_o,
   output reg  [1:0] speed_cmd_select_o,
   output reg  [1:0] torque_cmd_select_o,
   output reg  [2:0] position_cmd_select_o,
   output reg        position_trigger_o,
   output reg        servo_on_input_o,
   output reg        pulse_o
);
   initial begin
      {mode_switch_o, speed_cmd_select_o, torque_cmd_select_o, position_cmd_select_o} = 8'h00;
      {position_trigger_o, servo_on_input_o, pulse_o} = 3'h0;
   end
   // Levels change just after an edge and stay until the next call
   task set_in(input s, input [1:0] sp, input [1:0] tq, input [2:0] ps, input on);
      begin
         @(posedge clk_i);
         {mode_switch_o, speed_cmd_select_o, torque_cmd_select_o} <= {s, sp, tq};
         {position_cmd_select_o, servo_on_input_o} <= {ps, on};
      end
   endtask
   // Each level is held 7 cycles so the synchroniser sees it
   task strobe(input integer n, input trig);
      integer m;
      begin
         for (m = 0; m < 2 * n; m = m + 1) begin
            @(posedge clk_i);
            if (trig)
               position_trigger_o <= ~position_trigger_o;
            else
               pulse_o <= ~pulse_o;
            repeat (6) @(posedge clk_i);
         end
      end
   endtask
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the dual-mode selector
`timescale 1ns/1ps
`include "sdm_regs.vh"
module tb_top;
   localparam [20:0] ON_M  = 21'h02_2658;
   localparam [20:0] OFF_M = 21'h01_C508;
   reg         clk_i, rst_i, cyc_i, stb_i, we_i;
   reg  [7:0]  adr_i;
   reg  [31:0] dat_i, rd, cnt;
   reg  [15:0] spd [0:3];
   reg  [15:0] trq [0:3];
   reg  [31:0] tab [0:7];
   wire        ack_o, sw, servo_on_input, trg, pls, lim_en, p_val, hold;
   wire [1:0]  ssel, tsel;
   wire [2:0]  psel, mode;
   wire [15:0] s_cmd, t_cmd, s_lim;
   wire [31:0] dat_o, p_cmd;
   integer     fails, checked, seed, i, j, k;
   sdm_dual_mode_selector dut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .mode_switch_i(sw),
      .speed_cmd_select_i(ssel), .torque_cmd_select_i(tsel), .position_cmd_select_i(psel),
      .position_trigger_i(trg), .servo_on_input_i(servo_on_input), .pulse_i(pls), .pulse_dir_i(1'b0),
      .analog_speed_i(spd[0]), .analog_torque_i(trq[0]), .active_mode_o(mode), .speed_cmd_o(s_cmd),
      .torque_cmd_o(t_cmd), .speed_limit_o(s_lim), .speed_limit_en_o(lim_en), .position_cmd_o(p_cmd),
      .position_valid_o(p_val), .motor_hold_o(hold));
   sdm_ctrl_model u_ctl (.clk_i(clk_i), .mode_switch_o(sw), .speed_cmd_select_o(ssel),
      .torque_cmd_select_o(tsel), .position_cmd_select_o(psel), .position_trigger_o(trg),
      .servo_on_input_o(servo_on_input), .pulse_o(pls));
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   task finish_test;
      begin
         $display("Compares %0d mismatches %0d", checked, fails);
         if (fails == 0 && checked > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // Classic single cycle, held until ack is seen at a rising edge
   task bus(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge clk_i);
         {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
         k = 0;
         do begin
            @(posedge clk_i);
            k = k + 1;
         end while (ack_o !== 1'b1 && k < 20);
         rd = dat_o;
         {cyc_i, stb_i} <= 2'b00;
         if (ack_o !== 1'b1) begin
            fails = fails + 1;
            finish_test;
         end
      end
   endtask
   task settle;
      repeat (12) @(posedge clk_i);
   endtask
   initial begin
      seed = 32'h74a7;
      fails = 0;
      checked = 0;
      rst_i = 1'b1;
      {cyc_i, stb_i, we_i, adr_i, dat_i} = 43'h0;
      for (i = 0; i < 4; i = i + 1) begin
         spd[i] = $random(seed) & 16'h3FFF | 16'h0100;
         trq[i] = $random(seed) & 16'h3FFF;
      end
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(0, `SDM_ADR_MAXSPD, 0);
      chk(rd, 32'h0000_7FFF);
      bus(0, 8'h30, 0);
      chk(rd, 0);
      for (i = 1; i < 4; i = i + 1) begin
         bus(1, 4 * i, spd[i]);
         bus(1, 8'h0C + 4 * i, trq[i]);
      end
      for (i = 0; i < 8; i = i + 1) begin
         tab[i] = $random(seed);
         bus(1, 8'h40 + 4 * i, tab[i]);
         bus(0, 8'h40 + 4 * i, 0);
         chk(rd, tab[i]);
      end
      for (i = 5; i < 12; i = i + 1)
         for (j = 0; j < 2; j = j + 1) begin
            bus(1, 0, i);
            u_ctl.set_in(j, 0, 0, 0, 1);
            settle;
            chk(mode, j ? ON_M[(i - 5) * 3 +: 3] : OFF_M[(i - 5) * 3 +: 3]);
            chk(hold, i == 8 && j == 0);
         end
      $display("Test modes done");
      bus(1, 0, 32'h0000_003A);
      for (j = 0; j < 4; j = j + 1) begin
         u_ctl.set_in(0, j, 3, 0, 1);
         settle;
         chk(s_cmd, spd[j]);
         chk(t_cmd, 0);
      end
      for (j = 0; j < 4; j = j + 1) begin
         u_ctl.set_in(1, 2, j, 0, 1);
         settle;
         chk(t_cmd, trq[j]);
         chk(lim_en, 1);
         chk(s_lim, spd[2]);
      end
      bus(1, `SDM_ADR_MAXSPD, 32'h0000_0010);
      bus(1, 0, 32'h0000_000A);
      u_ctl.set_in(1, 2, 0, 0, 1);
      settle;
      chk(t_cmd, 0);
      chk(lim_en, 0);
      chk(s_lim, 16'h0010);
      u_ctl.set_in(0, 2, 0, 0, 1);
      settle;
      chk(s_cmd, 16'h0010);
      u_ctl.set_in(1, 2, 1, 0, 0);
      settle;
      chk(t_cmd, 0);
      $display("Test commands done");
      bus(1, 0, 32'h0000_0008);
      u_ctl.set_in(1, 0, 0, 5, 1);
      u_ctl.strobe(1, 1);
      chk(mode, 3'h3);
      chk(p_val, 0);
      u_ctl.set_in(0, 0, 0, 5, 1);
      settle;
      chk(hold, 1);
      u_ctl.strobe(1, 1);
      chk(p_cmd, tab[5]);
      chk(p_val, 1);
      u_ctl.set_in(1, 0, 0, 5, 1);
      settle;
      chk(mode, 3'h3);
      bus(1, 0, 32'h0000_0007);
      settle;
      bus(0, `SDM_ADR_PCOUNT, 0);
      cnt = rd;
      u_ctl.strobe(3, 0);
      bus(0, `SDM_ADR_PCOUNT, 0);
      chk(rd, cnt + 3);
      u_ctl.set_in(0, 0, 0, 5, 1);
      u_ctl.strobe(2, 0);
      bus(0, `SDM_ADR_PCOUNT, 0);
      chk(rd, cnt + 3);
      chk(mode, 3'h4);
      u_ctl.set_in(1, 0, 0, 5, 1);
      settle;
      chk(mode, 3'h1);
      $display("Test position done");
      finish_test;
   end
endmodule
